// *** core/uec_pkg.sv ***
// Purpose: Constants and types of the USB endpoint control block
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes:   Register byte addresses are four times the register index

package uec_pkg;

  localparam logic [7:0] UEC_IDX_BASE_HI = 8'h26;
  localparam logic [7:0] UEC_IDX_BASE_LO = 8'h27;
  localparam logic [7:0] UEC_IDX_DEVICE_ADDRESS_REG   = 8'h2b;
  localparam logic [7:0] UEC_IDX_TX0     = 8'h2c;
  localparam logic [7:0] UEC_IDX_RX0     = 8'h2d;
  localparam logic [7:0] UEC_IDX_TX1     = 8'h2e;
  localparam logic [7:0] UEC_IDX_RX1     = 8'h2f;
  localparam logic [7:0] UEC_IDX_TX2     = 8'h30;
  localparam logic [7:0] UEC_IDX_RX2     = 8'h31;
  localparam logic [7:0] UEC_IDX_CTRL    = 8'h40;
  localparam logic [7:0] UEC_IDX_STAT    = 8'h41;

  localparam logic [7:0] UEC_DEVICE_ADDRESS_REG_RST   = 8'h00;
  localparam logic [7:0] UEC_TX_RST      = 8'h00;
  localparam logic [7:0] UEC_RX_RST      = 8'h00;
  localparam logic [7:0] UEC_RX0_RST     = 8'h80;
  localparam logic [7:0] UEC_RX0_FORCE1  = 8'h80;
  localparam logic [7:0] UEC_RX0_KEEP    = 8'h70;
  localparam logic [7:0] UEC_DEVICE_ADDRESS_REG_MASK  = 8'h7f;

  localparam int UEC_BIT_STOUT = 7;
  localparam int UEC_BIT_CTL   = 7;
  localparam int UEC_BIT_TOG   = 6;
  localparam int UEC_STAT_HI   = 5;
  localparam int UEC_STAT_LO   = 4;

  localparam logic [1:0] UEC_ST_DIS   = 2'h0;
  localparam logic [1:0] UEC_ST_STALL = 2'h1;
  localparam logic [1:0] UEC_ST_NAK   = 2'h2;
  localparam logic [1:0] UEC_ST_VALID = 2'h3;

  localparam logic [1:0] UEC_PID_OUT   = 2'h0;
  localparam logic [1:0] UEC_PID_IN    = 2'h2;
  localparam logic [1:0] UEC_PID_SETUP = 2'h3;

  localparam logic [1:0] UEC_HS_NONE  = 2'h0;
  localparam logic [1:0] UEC_HS_ACK   = 2'h1;
  localparam logic [1:0] UEC_HS_NAK   = 2'h2;
  localparam logic [1:0] UEC_HS_STALL = 2'h3;

  localparam int UEC_NEP = 3;
  localparam logic [3:0] UEC_MAX_CNT = 4'h8;

  // Token seen by the serial engine
  typedef struct packed {
    logic       valid;
    logic [1:0] pid;
    logic [6:0] addr;
    logic [3:0] ep;
  } uec_token_t;

  // Completion report of the serial engine
  typedef struct packed {
    logic       valid;
    logic       ok;
    logic       data_pid;
    logic [3:0] count;
    logic       ack_in;
  } uec_done_t;

  // Answer back to the serial engine
  typedef struct packed {
    logic       hit;
    logic [1:0] ep;
    logic [1:0] hs;
    logic       pid1;
    logic [3:0] count;
    logic [15:0] buf_addr;
  } uec_resp_t;

  typedef struct packed {
    logic [7:0]          device_address_reg;
    logic [2:0][7:0]     tx;
    logic [2:0][7:0]     rx;
    logic [7:0]          base_hi;
    logic [1:0]          base_lo;
    logic                forced_interface_reset;
    logic                ctr;
    logic [1:0]          last_ep;
    logic [1:0]          last_pid;
    logic [1:0]          cur_ep;
    logic [1:0]          cur_pid;
    logic                cur_dir_in;
    logic                cur_hit;
    uec_resp_t           resp;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
  } uec_state_t;

endpackage

// *** core/uec_core.sv ***
// Purpose: Endpoint control registers of a low-speed USB device interface
// Assumes: Serial engine decodes tokens and reports completions
// Notes:   APB slave answers one cycle after setup, no wait states

`timescale 1ns/100ps

module uec_core
  import uec_pkg::*;
(
  input  wire logic        REF_CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [31:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic [3:0]  PSTRB_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        BUS_RESET_I,
  input  wire uec_token_t  TOKEN_I,
  input  wire uec_done_t   DONE_I,
  output uec_resp_t        RESP_O,
  output logic             CTR_O,
  output logic             FORCED_INTERFACE_RESET_O
);

  uec_state_t s_r;
  uec_state_t s_nxt;

  logic       usb_rst;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] idx;
  logic [7:0] wb;
  logic [2:0] ep_hit;
  logic [1:0] ep_sel;
  logic       any_hit;
  logic [7:0] txr;
  logic [7:0] rxr;

  // ***********************************************
  // Endpoint match, one lane per endpoint
  // ***********************************************
  genvar g;
  generate
    for (g = 0; g < UEC_NEP; g++)
    begin : g_match
      if (g == 0)
      begin : g_ep0
        assign ep_hit[g] = (TOKEN_I.ep == 4'h0);
      end
      else
      begin : g_epn
        assign ep_hit[g] = (TOKEN_I.ep == s_r.rx[g][3:0]);
      end
    end
  endgenerate

  assign usb_rst = BUS_RESET_I | s_r.forced_interface_reset;
  assign idx     = PADDR_I[9:2];
  assign wb      = PWDATA_I[7:0];
  assign wr_en   = PSEL_I & PENABLE_I & s_r.pready & PWRITE_I & PSTRB_I[0];
  assign rd_en   = PSEL_I & ~PENABLE_I & ~PWRITE_I;

  always_comb
  begin
    ep_sel  = 2'h0;
    any_hit = 1'b0;
    // Endpoint zero first, so a cleared endpoint number never steals it
    if (ep_hit[0])
    begin
      any_hit = 1'b1;
    end
    else if (ep_hit[1])
    begin
      ep_sel  = 2'h1;
      any_hit = 1'b1;
    end
    else if (ep_hit[2])
    begin
      ep_sel  = 2'h2;
      any_hit = 1'b1;
    end
  end

  assign txr = s_r.tx[ep_sel];
  assign rxr = s_r.rx[ep_sel];

  // ***********************************************
  // Next state
  // ***********************************************
  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;
    s_nxt.resp.hs = UEC_HS_NONE;

    // Register writes take effect in the access cycle of the transfer
    if (wr_en)
    begin
      case (idx)
        UEC_IDX_DEVICE_ADDRESS_REG:   s_nxt.device_address_reg = wb & UEC_DEVICE_ADDRESS_REG_MASK;
        UEC_IDX_TX0:     s_nxt.tx[0] = wb;
        UEC_IDX_TX1:     s_nxt.tx[1] = wb;
        UEC_IDX_TX2:     s_nxt.tx[2] = wb;
        UEC_IDX_RX0:     s_nxt.rx[0] = (wb & UEC_RX0_KEEP) | UEC_RX0_FORCE1;
        UEC_IDX_RX1:     s_nxt.rx[1] = wb;
        UEC_IDX_RX2:     s_nxt.rx[2] = wb;
        UEC_IDX_BASE_HI: s_nxt.base_hi = wb;
        UEC_IDX_BASE_LO: s_nxt.base_lo = wb[7:6];
        UEC_IDX_CTRL:    s_nxt.forced_interface_reset = wb[0];
        // Writing one clears the correct-transfer flag
        UEC_IDX_STAT:    s_nxt.ctr = s_r.ctr & ~wb[0];
        default:         s_nxt.pslverr = 1'b0;
      endcase
    end

    if (rd_en)
    begin
      case (idx)
        // Address reads zero while a forced reset is clearing it
        UEC_IDX_DEVICE_ADDRESS_REG:   s_nxt.prdata = {24'h0,
                                         s_r.forced_interface_reset ? UEC_DEVICE_ADDRESS_REG_RST
                                                  : s_r.device_address_reg};
        UEC_IDX_TX0:     s_nxt.prdata = {24'h0, s_r.tx[0]};
        UEC_IDX_TX1:     s_nxt.prdata = {24'h0, s_r.tx[1]};
        UEC_IDX_TX2:     s_nxt.prdata = {24'h0, s_r.tx[2]};
        UEC_IDX_RX0:     s_nxt.prdata = {24'h0, s_r.rx[0]};
        UEC_IDX_RX1:     s_nxt.prdata = {24'h0, s_r.rx[1]};
        UEC_IDX_RX2:     s_nxt.prdata = {24'h0, s_r.rx[2]};
        UEC_IDX_BASE_HI: s_nxt.prdata = {24'h0, s_r.base_hi};
        UEC_IDX_BASE_LO: s_nxt.prdata = {24'h0, s_r.base_lo, s_r.last_ep,
                                         4'h0};
        UEC_IDX_CTRL:    s_nxt.prdata = {31'h0, s_r.forced_interface_reset};
        UEC_IDX_STAT:    s_nxt.prdata = {27'h0, s_r.last_pid, s_r.last_ep,
                                         s_r.ctr};
        default:         s_nxt.prdata = 32'h0;
      endcase
    end
    if (PSEL_I & ~PENABLE_I)
    begin
      s_nxt.pready = 1'b1;
    end

    // Token handling: decide handshake and buffer for this endpoint
    if (TOKEN_I.valid)
    begin
      s_nxt.resp.hit = 1'b0;
      s_nxt.cur_hit  = 1'b0;
      if (any_hit && TOKEN_I.addr == s_r.device_address_reg[6:0])
      begin
        s_nxt.cur_ep     = ep_sel;
        s_nxt.cur_pid    = TOKEN_I.pid;
        s_nxt.cur_dir_in = (TOKEN_I.pid == UEC_PID_IN);
        s_nxt.resp.hit   = 1'b1;
        s_nxt.resp.ep    = ep_sel;
        // Buffers: RX at 8*(2*ep), TX at 8*(2*ep+1), filled upward
        s_nxt.resp.buf_addr = {s_r.base_hi, s_r.base_lo,
                               ep_sel, TOKEN_I.pid == UEC_PID_IN,
                               3'h0};
        s_nxt.resp.count = txr[3:0];
        s_nxt.resp.pid1  = txr[UEC_BIT_TOG];
        if (TOKEN_I.pid == UEC_PID_IN)
        begin
          case (txr[UEC_STAT_HI:UEC_STAT_LO])
            UEC_ST_VALID: s_nxt.resp.hs = s_r.ctr ? UEC_HS_NAK : UEC_HS_ACK;
            UEC_ST_STALL: s_nxt.resp.hs = UEC_HS_STALL;
            UEC_ST_NAK:   s_nxt.resp.hs = UEC_HS_NAK;
            default:      s_nxt.resp.hit = 1'b0;
          endcase
        end
        else if (TOKEN_I.pid == UEC_PID_SETUP && ep_sel != 2'h0
                 && !rxr[UEC_BIT_CTL])
        begin
          s_nxt.resp.hit = 1'b0;
        end
        else
        begin
          case (rxr[UEC_STAT_HI:UEC_STAT_LO])
            UEC_ST_VALID: s_nxt.resp.hs = s_r.ctr ? UEC_HS_NAK : UEC_HS_ACK;
            UEC_ST_STALL: s_nxt.resp.hs = UEC_HS_STALL;
            UEC_ST_NAK:   s_nxt.resp.hs = UEC_HS_NAK;
            default:      s_nxt.resp.hit = 1'b0;
          endcase
        end
        // Only an accepted transaction waits for its completion
        s_nxt.cur_hit = s_nxt.resp.hit & (s_nxt.resp.hs == UEC_HS_ACK);
        if (TOKEN_I.pid == UEC_PID_SETUP)
        begin
          s_nxt.tx[ep_sel][UEC_BIT_TOG] = 1'b1;
          s_nxt.rx[ep_sel][UEC_BIT_TOG] = 1'b0;
        end
      end
    end

    // Completion of a transaction from the serial engine
    if (DONE_I.valid && s_r.cur_hit)
    begin
      s_nxt.cur_hit = 1'b0;
      if (s_r.cur_dir_in)
      begin
        if (DONE_I.ack_in)
        begin
          s_nxt.tx[s_r.cur_ep][UEC_BIT_TOG] =
            ~s_r.tx[s_r.cur_ep][UEC_BIT_TOG];
          s_nxt.tx[s_r.cur_ep][UEC_STAT_HI:UEC_STAT_LO] = UEC_ST_NAK;
          s_nxt.ctr      = 1'b1;
          s_nxt.last_ep  = s_r.cur_ep;
          s_nxt.last_pid = s_r.cur_pid;
        end
      end
      else if (DONE_I.ok
               && DONE_I.data_pid == s_r.rx[s_r.cur_ep][UEC_BIT_TOG])
      begin
        if (s_r.cur_pid == UEC_PID_OUT
            && s_r.tx[s_r.cur_ep][UEC_BIT_STOUT]
            && DONE_I.count != 4'h0)
        begin
          // Status stage expected zero bytes: refuse the data
          s_nxt.resp.hs = UEC_HS_STALL;
        end
        else
        begin
          s_nxt.rx[s_r.cur_ep][UEC_BIT_TOG] =
            ~s_r.rx[s_r.cur_ep][UEC_BIT_TOG];
          s_nxt.rx[s_r.cur_ep][UEC_STAT_HI:UEC_STAT_LO] = UEC_ST_NAK;
          if (s_r.cur_pid == UEC_PID_SETUP)
          begin
            s_nxt.tx[s_r.cur_ep][UEC_STAT_HI:UEC_STAT_LO] = UEC_ST_NAK;
          end
          s_nxt.ctr      = 1'b1;
          s_nxt.last_ep  = s_r.cur_ep;
          s_nxt.last_pid = s_r.cur_pid;
        end
      end
    end

    // USB bus reset or forced reset overrides the address, endpoint registers, pending transfer and response
    if (usb_rst)
    begin
      s_nxt.device_address_reg   = UEC_DEVICE_ADDRESS_REG_RST;
      s_nxt.tx      = {UEC_NEP{UEC_TX_RST}};
      s_nxt.rx[0]   = UEC_RX0_RST;
      s_nxt.rx[1]   = UEC_RX_RST;
      s_nxt.rx[2]   = UEC_RX_RST;
      s_nxt.cur_hit = 1'b0;
      s_nxt.resp    = '0;
    end
  end

  // ***********************************************
  // State register
  // ***********************************************
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      s_r       <= '0;
      s_r.rx[0] <= UEC_RX0_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign PRDATA_O  = s_r.prdata;
  assign PREADY_O  = s_r.pready;
  assign PSLVERR_O = s_r.pslverr;
  assign RESP_O    = s_r.resp;
  assign CTR_O     = s_r.ctr;
  assign FORCED_INTERFACE_RESET_O    = s_r.forced_interface_reset;

endmodule

// *** verif/uec_asserts.sv ***
// Purpose: Port checker for the USB endpoint control block
// Assumes: Wait-free APB answers and registered outputs
// Notes:   Bound to every instance of the core
`timescale 1ns/100ps
module uec_asserts
  import uec_pkg::*;
(
  input  wire logic        REF_CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [31:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic [3:0]  PSTRB_I,
  input  wire logic [31:0] PRDATA_O,
  input  wire logic        PREADY_O,
  input  wire logic        PSLVERR_O,
  input  wire logic        BUS_RESET_I,
  input  wire uec_token_t  TOKEN_I,
  input  wire uec_done_t   DONE_I,
  input  wire uec_resp_t   RESP_O,
  input  wire logic        CTR_O,
  input  wire logic        FORCED_INTERFACE_RESET_O
);
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  logic       rd_v;
  logic [7:0] idx_v;
  assign rd_v  = PSEL_I && PENABLE_I && !PWRITE_I && PREADY_O;
  assign idx_v = PADDR_I[9:2];
  a_apb_answer: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
    else $error("ready missing after setup");
  a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held too long");
  a_rd_upper: assert property (rd_v |-> PRDATA_O[31:8] == 24'h0 && !PSLVERR_O)
    else $error("read upper bits or error set");
  a_addr_top: assert property (rd_v && idx_v == UEC_IDX_DEVICE_ADDRESS_REG |-> !PRDATA_O[7])
    else $error("address top bit set");
  a_rx0_fixed: assert property (rd_v && idx_v == UEC_IDX_RX0 |-> PRDATA_O[7] && PRDATA_O[3:0] == 4'h0)
    else $error("endpoint zero receive fixed bits wrong");
  a_forced_interface_reset_clear: assert property (FORCED_INTERFACE_RESET_O && rd_v && idx_v == UEC_IDX_DEVICE_ADDRESS_REG |-> PRDATA_O[7:0] == 8'h00)
    else $error("address kept in forced reset");
  a_busrst_quiet: assert property (BUS_RESET_I ##1 TOKEN_I.valid |=> !RESP_O.hit && RESP_O.hs == UEC_HS_NONE)
    else $error("answer after bus reset");
  a_idle_no_hs: assert property (!TOKEN_I.valid && !DONE_I.valid |=> RESP_O.hs == UEC_HS_NONE)
    else $error("handshake without cause");
  a_ctr_naks: assert property (CTR_O && TOKEN_I.valid |=> RESP_O.hs != UEC_HS_ACK)
    else $error("ack while transfer flag pending");
endmodule
bind uec_core uec_asserts uec_asserts_inst (.*);

// *** verif/uec_host_model.sv ***
// Purpose: Host and serial engine stand-in driving tokens and completions
// Assumes: One transaction at a time
// Notes:   Idle fields carry noise so stale values never pass
`timescale 1ns/100ps
module uec_host_model
  import uec_pkg::*;
(
  input  wire logic      clk_i,
  input  wire uec_resp_t resp_i,
  output uec_token_t     tok_o,
  output uec_done_t      done_o
);
  initial
  begin
    tok_o = '0;
    done_o = '0;
  end
  task automatic send_token(input logic [1:0] p, input logic [6:0] a,
                            input logic [3:0] e, output uec_resp_t r);
    @(posedge clk_i);
    tok_o <= {1'b1, p, a, e};
    @(posedge clk_i);
    tok_o <= {1'b0, 13'($urandom)};
    @(negedge clk_i);
    r = resp_i;
  endtask
  // Gap lets the host answer promptly or slowly
  task automatic send_done(input logic ok, input logic pid,
                           input logic [3:0] n, input logic ack,
                           input int gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    done_o <= {1'b1, ok, pid, n, ack};
    @(posedge clk_i);
    done_o <= {1'b0, 7'($urandom)};
    repeat (2) @(posedge clk_i);
  endtask
endmodule

// *** verif/uec_core_tb_top.sv ***
// Purpose: Self-checking bench for the USB endpoint control block
// Assumes: Register model kept in an integer array
// Notes:   Transfers run through the host stand-in
`timescale 1ns/100ps
module uec_core_tb_top;
  import uec_pkg::*;
  logic        clk, rstn, psel, pen, pwr, bus_rst, ctr, forced_interface_reset, pready, perr;
  logic [31:0] paddr, pwdata, prdata, r;
  logic [9:0]  b;
  logic [3:0]  c;
  logic [7:0]  v;
  logic [1:0]  hs_seen = 2'h0;
  uec_token_t  tok;
  uec_done_t   done;
  uec_resp_t   resp, rs;
  int          m [256];
  int          fail_count, checked, seed;
  uec_core uec_core_inst (.REF_CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PSTRB_I(4'hf), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(perr), .BUS_RESET_I(bus_rst), .TOKEN_I(tok),
    .DONE_I(done), .RESP_O(resp), .CTR_O(ctr), .FORCED_INTERFACE_RESET_O(forced_interface_reset));
  uec_host_model uec_host_model_inst (.clk_i(clk), .resp_i(resp),
    .tok_o(tok), .done_o(done));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (resp.hs !== 2'h0) hs_seen <= resp.hs;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (fail_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] i,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= {22'h0, i, 2'h0};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      fail_count++;
      final_report();
    end
    q = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, i, {24'h0, d}, q);
    if (i == UEC_IDX_DEVICE_ADDRESS_REG) m[i] = d & 8'h7f;
    else if (i == UEC_IDX_RX0) m[i] = (d & 8'h70) | 8'h80;
    else if (i > UEC_IDX_DEVICE_ADDRESS_REG && i <= UEC_IDX_RX2) m[i] = d;
  endtask
  task automatic rd(input logic [7:0] i);
    logic [31:0] q;
    apb(1'b0, i, 32'h0, q);
    check(q, 32'(m[i]));
  endtask
  task automatic mreset();
    for (int k = 8'h2b; k <= 8'h31; k++) m[k] = 0;
    m[UEC_IDX_RX0] = 8'h80;
  endtask
  initial
  begin
    {rstn, psel, pen, pwr, bus_rst, paddr, pwdata} = '0;
    seed = $urandom(95);
    mreset();
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int k = 8'h2b; k <= 8'h31; k++) rd(8'(k));
    for (int k = 8'h2b; k <= 8'h31; k++)
    begin
      v = 8'($urandom);
      if (k[0] == 1'b0) v[3:0] = 4'($urandom_range(8));
      wr(8'(k), v);
      rd(8'(k));
    end
    wr(8'h10, 8'($urandom));
    rd(8'h10);
    wr(UEC_IDX_TX0, {2'h0, UEC_ST_VALID, 4'h2});
    @(posedge clk) bus_rst <= 1'b1;
    fork
      @(posedge clk) bus_rst <= 1'b0;
      uec_host_model_inst.send_token(UEC_PID_IN, 7'h00, 4'h0, rs);
    join
    check(rs.hit, 1'b0);
    mreset();
    for (int k = 8'h2b; k <= 8'h31; k++) rd(8'(k));
    wr(UEC_IDX_DEVICE_ADDRESS_REG, 8'h5a);
    wr(UEC_IDX_CTRL, 8'h01);
    @(posedge clk);
    check(forced_interface_reset, 1'b1);
    mreset();
    for (int k = 8'h2b; k <= 8'h31; k++) rd(8'(k));
    wr(UEC_IDX_CTRL, 8'h00);
    b = 10'($urandom);
    c = 4'($urandom_range(8));
    wr(UEC_IDX_BASE_HI, b[9:2]);
    wr(UEC_IDX_BASE_LO, {b[1:0], 6'h0});
    wr(UEC_IDX_DEVICE_ADDRESS_REG, 8'h05);
    wr(UEC_IDX_TX0, {2'h0, UEC_ST_VALID, c});
    uec_host_model_inst.send_token(UEC_PID_IN, 7'h05, 4'h0, rs);
    check({rs.hit, rs.ep, rs.pid1, rs.count, rs.buf_addr},
          {1'b1, 2'h0, 1'b0, c, b, 2'h0, 1'b1, 3'h0});
    uec_host_model_inst.send_done(1'b1, 1'b0, 4'h0, 1'b1, $urandom_range(3));
    m[UEC_IDX_TX0] = {2'h1, UEC_ST_NAK, c};
    rd(UEC_IDX_TX0);
    check(ctr, 1'b1);
    wr(UEC_IDX_TX0, {2'h1, UEC_ST_VALID, c});
    uec_host_model_inst.send_token(UEC_PID_IN, 7'h05, 4'h0, rs);
    check(rs.hs, UEC_HS_NAK);
    wr(UEC_IDX_STAT, 8'h01);
    @(posedge clk);
    check(ctr, 1'b0);
    uec_host_model_inst.send_token(UEC_PID_IN, 7'h05, 4'h0, rs);
    check(rs.pid1, 1'b1);
    uec_host_model_inst.send_done(1'b0, 1'b1, 4'h0, 1'b0, 0);
    rd(UEC_IDX_TX0);
    wr(UEC_IDX_RX1, {2'h0, UEC_ST_VALID, 4'h1});
    wr(UEC_IDX_TX1, {2'h2, UEC_ST_NAK, 4'h0});
    uec_host_model_inst.send_token(UEC_PID_OUT, 7'h05, 4'h1, rs);
    uec_host_model_inst.send_done(1'b1, 1'b0, 4'h2, 1'b0, 1);
    check(hs_seen, UEC_HS_STALL);
    wr(UEC_IDX_STAT, 8'h01);
    wr(UEC_IDX_TX1, 8'h00);
    wr(UEC_IDX_RX1, {2'h0, UEC_ST_VALID, 4'h1});
    uec_host_model_inst.send_token(UEC_PID_OUT, 7'h05, 4'h1, rs);
    uec_host_model_inst.send_done(1'b1, 1'b0, 4'h2, 1'b0, 2);
    m[UEC_IDX_RX1] = {2'h1, UEC_ST_NAK, 4'h1};
    rd(UEC_IDX_RX1);
    wr(UEC_IDX_STAT, 8'h01);
    wr(UEC_IDX_RX1, {2'h1, UEC_ST_VALID, 4'h1});
    uec_host_model_inst.send_token(UEC_PID_OUT, 7'h05, 4'h1, rs);
    uec_host_model_inst.send_done(1'b1, 1'b0, 4'h2, 1'b0, 0);
    rd(UEC_IDX_RX1);
    wr(UEC_IDX_STAT, 8'h01);
    wr(UEC_IDX_RX0, {2'h1, UEC_ST_VALID, 4'h0});
    wr(UEC_IDX_TX0, {2'h0, UEC_ST_VALID, 4'h0});
    uec_host_model_inst.send_token(UEC_PID_SETUP, 7'h05, 4'h0, rs);
    uec_host_model_inst.send_done(1'b1, 1'b0, 4'h8, 1'b0, 1);
    m[UEC_IDX_RX0] = 8'he0;
    m[UEC_IDX_TX0] = 8'h60;
    rd(UEC_IDX_RX0);
    rd(UEC_IDX_TX0);
    final_report();
  end
endmodule
